/* logic/ueoc_top.sv */
// out endpoint control with in endpoint configuration byte
// Function
// - in double buffer bit enables in double buffering
// - in iso bit selects iso or bulk
// - out endpoint supports interrupt, bulk, iso
// - bulk and interrupt handled identically
// - out interrupt only on ready, stall or overrun
// - iso bit zero means bulk/interrupt mode
// - bulk out packet sets ready, raises interrupt
// - byte count of current packet in registers
// - send stall answers every bulk/interrupt out with stall, iso outs are not stalled
// - each stall sets stall sent, raises interrupt
// - second buffered packet re-sets ready at once
// - iso packet stored, ready set, interrupt
// - iso packet without room sets overrun
// - iso crc error stored, data error set
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module ueoc_top
  import ueoc_pkg::*;
(
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [7:0]       reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [7:0]       reg_rdata_out,
  input  wire logic             rx_pkt_valid_in,
  input  wire ueoc_pkg::ueoc_count_type rx_pkt_count_in,
  input  wire logic             rx_crc_err_in,
  input  wire logic             in_pkt_sent_in,
  input  wire logic             in_ack_in,
  output logic                  out_ack_out,
  output logic                  out_nak_out,
  output logic                  out_stall_out,
  output logic                  out_irq_out,
  output logic                  out_toggle_out,
  output logic                  in_toggle_out,
  output logic                  in_double_buffer_out,
  output logic                  in_iso_out,
  output logic                  ep_in_active_out,
  output logic                  ep_out_active_out,
  output logic                  fifo_split_out
);
  import ueoc_pkg::*;

  logic [7:0]     in_cfg_r;
  logic           send_stall_r;
  logic           stall_sent_r;
  logic           overrun_r;
  logic           out_dbl_r;
  logic           out_iso_r;
  logic           opr_r;
  logic [1:0]     used_r;
  logic [1:0]     used_nxt;
  logic           wr_idx_r;
  logic           rd_idx_r;
  ueoc_count_type cnt_r [SLOTS];
  logic           err_r [SLOTS];
  logic           tog_out_r;
  logic           tog_in_r;
  logic [7:0]     rdata_nxt;
  logic           wr_low;
  logic           room;
  logic           do_stall;
  logic           do_store;
  logic           do_overrun;
  logic           pop;

  // register write decode
  assign wr_low   = reg_wr_in && (reg_addr_in == OUT_CTRL_LOW_OFS);
  assign room     = used_r < (out_dbl_r ? USED_TWO : USED_ONE);
  // bulk and interrupt share one path, only iso differs
  assign do_stall   = rx_pkt_valid_in && !out_iso_r && send_stall_r;
  assign do_store   = rx_pkt_valid_in && room && !do_stall
                      && (out_iso_r || !rx_crc_err_in);
  assign do_overrun = rx_pkt_valid_in && out_iso_r && !room;
  // firmware clear of ready or flush releases the head slot
  assign pop = opr_r && wr_low && (!reg_wdata_in[OUT_OPR_BIT] || reg_wdata_in[OUT_FLUSH_BIT]);

  always_comb
  begin
    used_nxt = used_r;
    if (do_store && !pop)
    begin
      used_nxt = used_r + USED_ONE;
    end
    else if (pop && !do_store)
    begin
      used_nxt = used_r - USED_ONE;
    end
  end

  // in endpoint configuration byte
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      in_cfg_r <= IN_CFG_HIGH_RST;
    end
    else if (reg_wr_in && (reg_addr_in == IN_CFG_HIGH_OFS))
    begin
      in_cfg_r <= reg_wdata_in & 8'hec;
    end
  end

  // out control high byte
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      out_dbl_r <= OUT_CTRL_HIGH_RST[OUT_DBL_BIT];
      out_iso_r <= OUT_CTRL_HIGH_RST[OUT_ISO_BIT];
    end
    else if (reg_wr_in && (reg_addr_in == OUT_CTRL_HIGH_OFS))
    begin
      out_dbl_r <= reg_wdata_in[OUT_DBL_BIT];
      out_iso_r <= reg_wdata_in[OUT_ISO_BIT];
    end
  end

  // send stall control
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      send_stall_r <= OUT_CTRL_LOW_RST[OUT_SEND_STALL_BIT];
    end
    else if (wr_low)
    begin
      send_stall_r <= reg_wdata_in[OUT_SEND_STALL_BIT];
    end
  end

  // sticky flags, hardware set wins over firmware clear
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stall_sent_r <= OUT_CTRL_LOW_RST[OUT_STSENT_BIT];
      overrun_r    <= OUT_CTRL_LOW_RST[OUT_OVR_BIT];
    end
    else
    begin
      if (do_stall)
      begin
        stall_sent_r <= 1'b1;
      end
      else if (wr_low && !reg_wdata_in[OUT_STSENT_BIT])
      begin
        stall_sent_r <= 1'b0;
      end
      if (do_overrun)
      begin
        overrun_r <= 1'b1;
      end
      else if (wr_low && !reg_wdata_in[OUT_OVR_BIT])
      begin
        overrun_r <= 1'b0;
      end
    end
  end

  // packet slots
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      used_r   <= USED_ZERO;
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      cnt_r[0] <= '0;
      cnt_r[1] <= '0;
      err_r[0] <= 1'b0;
      err_r[1] <= 1'b0;
    end
    else
    begin
      used_r <= used_nxt;
      if (do_store)
      begin
        cnt_r[wr_idx_r] <= rx_pkt_count_in;
        err_r[wr_idx_r] <= rx_crc_err_in;
        wr_idx_r        <= out_dbl_r ? !wr_idx_r : wr_idx_r;
      end
      if (pop)
      begin
        rd_idx_r <= out_dbl_r ? !rd_idx_r : rd_idx_r;
      end
    end
  end

  // ready flag follows held packets, so a second packet shows at once
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      opr_r <= OUT_CTRL_LOW_RST[OUT_OPR_BIT];
    end
    else
    begin
      opr_r <= (used_nxt != USED_ZERO);
    end
  end

  // interrupt and handshake pulses
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      out_irq_out   <= 1'b0;
      out_ack_out   <= 1'b0;
      out_nak_out   <= 1'b0;
      out_stall_out <= 1'b0;
    end
    else
    begin
      out_irq_out   <= do_stall || do_overrun
                       || ((!opr_r || pop) && (used_nxt != USED_ZERO));
      out_ack_out   <= do_store && !out_iso_r;
      out_nak_out   <= rx_pkt_valid_in && !out_iso_r && !send_stall_r && !room;
      out_stall_out <= do_stall;
    end
  end

  // data toggles
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tog_out_r <= 1'b0;
      tog_in_r  <= 1'b0;
    end
    else
    begin
      if (wr_low && reg_wdata_in[OUT_CLRTOG_BIT])
      begin
        tog_out_r <= 1'b0;
      end
      else if (do_store && !out_iso_r)
      begin
        tog_out_r <= !tog_out_r;
      end
      if (in_pkt_sent_in && (in_cfg_r[IN_FTOG_BIT] || in_ack_in))
      begin
        tog_in_r <= !tog_in_r;
      end
    end
  end

  // read mux
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        IN_CFG_HIGH_OFS:   rdata_nxt = in_cfg_r;
        OUT_CTRL_LOW_OFS:  rdata_nxt = {1'b0, stall_sent_r, send_stall_r, 1'b0,
                                        opr_r && out_iso_r && err_r[rd_idx_r],
                                        overrun_r,
                                        used_r == (out_dbl_r ? USED_TWO : USED_ONE),
                                        opr_r};
        OUT_CTRL_HIGH_OFS: rdata_nxt = {out_dbl_r, out_iso_r, 6'h00};
        OUT_CNT_LOW_OFS:   rdata_nxt = opr_r ? cnt_r[rd_idx_r][7:0] : 8'h00;
        OUT_CNT_HIGH_OFS:  rdata_nxt = opr_r ? {6'h00, cnt_r[rd_idx_r][9:8]} : 8'h00;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else
    begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // configuration outputs
  assign out_toggle_out       = tog_out_r;
  assign in_toggle_out        = tog_in_r;
  assign in_double_buffer_out = in_cfg_r[IN_DBL_BIT];
  assign in_iso_out           = in_cfg_r[IN_ISO_BIT];
  assign fifo_split_out       = in_cfg_r[IN_SPLIT_BIT];
  assign ep_in_active_out     = in_cfg_r[IN_SPLIT_BIT] || in_cfg_r[IN_DIR_BIT];
  assign ep_out_active_out    = in_cfg_r[IN_SPLIT_BIT] || !in_cfg_r[IN_DIR_BIT];

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_bulk_rx;
    rx_pkt_valid_in && !out_iso_r && !send_stall_r && room && !rx_crc_err_in;
  endsequence
  sequence s_ready_irq;
    opr_r && out_ack_out && (out_irq_out || $past(opr_r));
  endsequence

  a_stall_reply: assert property (rx_pkt_valid_in && !out_iso_r && send_stall_r
    |=> out_stall_out && stall_sent_r && out_irq_out && !out_ack_out)
    else $error("stall not answered");
  a_bulk_ready: assert property (s_bulk_rx |=> s_ready_irq)
    else $error("bulk packet did not raise ready");
  a_irq_cause: assert property (out_irq_out |-> opr_r || stall_sent_r || overrun_r)
    else $error("interrupt without cause");
  a_second_packet: assert property (pop && used_r == USED_TWO && !do_store
    |=> opr_r && out_irq_out)
    else $error("second packet not flagged");
  a_iso_overrun: assert property (rx_pkt_valid_in && out_iso_r && !room
    |=> overrun_r && out_irq_out && used_r <= $past(used_r))
    else $error("overrun not flagged");
  a_iso_crc_store: assert property (rx_pkt_valid_in && out_iso_r && room && rx_crc_err_in
    && used_r == USED_ZERO
    |=> opr_r && out_irq_out && err_r[rd_idx_r])
    else $error("crc packet not stored");
  a_toggle_forced: assert property (in_pkt_sent_in && in_cfg_r[IN_FTOG_BIT]
    |=> in_toggle_out != $past(in_toggle_out))
    else $error("forced toggle did not switch");
  a_toggle_hold: assert property (in_pkt_sent_in && !in_cfg_r[IN_FTOG_BIT] && !in_ack_in
    |=> $stable(in_toggle_out))
    else $error("toggle switched without ack");
  a_split_both: assert property (fifo_split_out |-> ep_in_active_out && ep_out_active_out)
    else $error("split fifo not shared");
  a_read_slot: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
endmodule

/* shared/ueoc_pkg.sv */
// package: offsets, field positions, reset values for the out endpoint control block
package ueoc_pkg;
  localparam logic [7:0] IN_CFG_HIGH_OFS   = 8'h12;
  localparam logic [7:0] OUT_CTRL_LOW_OFS  = 8'h14;
  localparam logic [7:0] OUT_CTRL_HIGH_OFS = 8'h15;
  localparam logic [7:0] OUT_CNT_LOW_OFS   = 8'h16;
  localparam logic [7:0] OUT_CNT_HIGH_OFS  = 8'h17;

  localparam logic [7:0] IN_CFG_HIGH_RST   = 8'h00;
  localparam logic [7:0] OUT_CTRL_LOW_RST  = 8'h00;
  localparam logic [7:0] OUT_CTRL_HIGH_RST = 8'h00;

  // in_endpoint_config_high fields
  localparam int IN_DBL_BIT    = 7;
  localparam int IN_ISO_BIT    = 6;
  localparam int IN_DIR_BIT    = 5;
  localparam int IN_FTOG_BIT   = 3;
  localparam int IN_SPLIT_BIT  = 2;

  // out_endpoint_control_low fields
  localparam int OUT_CLRTOG_BIT = 7;
  localparam int OUT_STSENT_BIT = 6;
  localparam int OUT_SEND_STALL_BIT  = 5;
  localparam int OUT_FLUSH_BIT  = 4;
  localparam int OUT_DERR_BIT   = 3;
  localparam int OUT_OVR_BIT    = 2;
  localparam int OUT_FULL_BIT   = 1;
  localparam int OUT_OPR_BIT    = 0;

  // out_endpoint_control_high fields
  localparam int OUT_DBL_BIT    = 7;
  localparam int OUT_ISO_BIT    = 6;

  localparam int CNT_W          = 10;
  localparam int SLOTS          = 2;
  localparam logic [1:0] USED_ZERO = 2'h0;
  localparam logic [1:0] USED_ONE  = 2'h1;
  localparam logic [1:0] USED_TWO  = 2'h2;

  typedef logic [CNT_W-1:0] ueoc_count_type;
endpackage

/* testbench/ueoc_host_model.sv */
// host side model: out data packets and in transmit reports
`timescale 1ns/10ps
module ueoc_host_model
  import ueoc_pkg::*;
(
  input  wire logic                      clk_in,
  output logic                           pkt_valid_out,
  output ueoc_pkg::ueoc_count_type       pkt_count_out,
  output logic                           crc_err_out,
  output logic                           in_sent_out,
  output logic                           in_ack_out
);
  initial
  begin
    pkt_valid_out = 1'b0;
    pkt_count_out = '0;
    crc_err_out   = 1'b0;
    in_sent_out   = 1'b0;
    in_ack_out    = 1'b0;
  end

  // one token plus data packet, qualifiers inverted once released
  task automatic send_out(input ueoc_count_type cnt, input logic crc);
    @(posedge clk_in);
    pkt_valid_out <= 1'b1;
    pkt_count_out <= cnt;
    crc_err_out   <= crc;
    @(posedge clk_in);
    pkt_valid_out <= 1'b0;
    pkt_count_out <= ~cnt;
    crc_err_out   <= ~crc;
  endtask

  // in packet sent, with or without handshake
  task automatic send_in(input logic ack);
    @(posedge clk_in);
    in_sent_out <= 1'b1;
    in_ack_out  <= ack;
    @(posedge clk_in);
    in_sent_out <= 1'b0;
    in_ack_out  <= ~ack;
  endtask
endmodule

/* testbench/test_ueoc_top.sv */
// self-checking bench for the out endpoint control block
`timescale 1ns/10ps
module test_ueoc_top;
  import ueoc_pkg::*;
  logic           ref_clk_in, arst_n_in, reg_wr_in, reg_rd_in, rd_d;
  logic [7:0]     reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic           pv, crc, isent, iack, ack, nak, stl, irq, otog, itog, dbl, iso, ein, eout, spl;
  ueoc_count_type pc, a, b;
  logic [7:0]     rd_q[$];
  logic [3:0]     ev_q[$];
  int             n_fail, comparisons;
  integer         seed;

  ueoc_top u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .rx_pkt_valid_in(pv), .rx_pkt_count_in(pc), .rx_crc_err_in(crc), .in_pkt_sent_in(isent),
    .in_ack_in(iack), .out_ack_out(ack), .out_nak_out(nak), .out_stall_out(stl), .out_irq_out(irq),
    .out_toggle_out(otog), .in_toggle_out(itog), .in_double_buffer_out(dbl), .in_iso_out(iso),
    .ep_in_active_out(ein), .ep_out_active_out(eout), .fifo_split_out(spl));

  ueoc_host_model u_host (.clk_in(ref_clk_in), .pkt_valid_out(pv), .pkt_count_out(pc),
    .crc_err_out(crc), .in_sent_out(isent), .in_ack_out(iack));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= ad;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge ref_clk_in);
    reg_addr_in <= ad;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
  endtask

  // expected events: {ack, nak, stall, irq}; zero means nothing shows
  task automatic pkt(input ueoc_count_type c, input logic e, input logic [3:0] ev);
    if (ev != 4'h0)
      ev_q.push_back(ev);
    u_host.send_out(c, e);
  endtask

  task automatic tog(input logic ak, input logic exp);
    u_host.send_in(ak);
    @(posedge ref_clk_in);
    chk({7'h0, itog}, {7'h0, exp});
  endtask

  // result watchers
  always @(posedge ref_clk_in)
  begin
    rd_d <= reg_rd_in;
    if (rd_d)
      chk(reg_rdata_out, (rd_q.size() > 0) ? rd_q.pop_front() : 8'h00);
    if (arst_n_in && (ack | nak | stl | irq))
      chk({4'h0, ack, nak, stl, irq}, {4'h0, (ev_q.size() > 0) ? ev_q.pop_front() : 4'h0});
  end

  initial
  begin
    #500000;
    n_fail++;
    finish_test;
  end

  initial
  begin
    n_fail = 0;
    comparisons = 0;
    seed = 57842;
    rd_d = 1'b0;
    arst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    repeat (4) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    rd(8'h12, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'hec);
    chk({3'h0, dbl, iso, spl, ein, eout}, 8'h1f);
    wr(8'h12, 8'h20);
    @(negedge ref_clk_in);
    chk({3'h0, dbl, iso, spl, ein, eout}, 8'h02);
    wr(8'h12, 8'h00);
    @(negedge ref_clk_in);
    chk({3'h0, dbl, iso, spl, ein, eout}, 8'h01);
    tog(1'b0, 1'b0);
    tog(1'b1, 1'b1);
    wr(8'h12, 8'h08);
    tog(1'b0, 1'b0);
    a = ueoc_count_type'($random(seed));
    b = ueoc_count_type'($random(seed));
    pkt(a, 1'b0, 4'h9);
    rd(8'h14, 8'h03);
    rd(8'h16, a[7:0]);
    rd(8'h17, {6'h0, a[9:8]});
    chk({7'h0, otog}, 8'h01);
    pkt(b, 1'b0, 4'h4);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h16, 8'h00);
    pkt(b, 1'b1, 4'h0);
    rd(8'h14, 8'h00);
    wr(8'h15, 8'h80);
    pkt(a, 1'b0, 4'h9);
    pkt(b, 1'b0, 4'h8);
    rd(8'h14, 8'h03);
    rd(8'h16, a[7:0]);
    ev_q.push_back(4'h1);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h01);
    rd(8'h16, b[7:0]);
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h20);
    pkt(a, 1'b0, 4'h3);
    rd(8'h14, 8'h60);
    wr(8'h14, 8'h60);
    rd(8'h14, 8'h60);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
    wr(8'h15, 8'h40);
    pkt(a, 1'b1, 4'h1);
    rd(8'h14, 8'h0b);
    pkt(b, 1'b0, 4'h1);
    rd(8'h14, 8'h0f);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
    wr(8'h15, 8'hc0);
    pkt(a, 1'b0, 4'h1);
    pkt(b, 1'b0, 4'h0);
    rd(8'h14, 8'h03);
    ev_q.push_back(4'h1);
    wr(8'h14, 8'h00);
    rd(8'h16, b[7:0]);
    wr(8'h14, 8'h11);
    rd(8'h14, 8'h00);
    wr(8'h14, 8'h80);
    @(negedge ref_clk_in);
    chk({7'h0, otog}, 8'h00);
    repeat (3) @(posedge ref_clk_in);
    chk({4'h0, rd_q.size() == 0, ev_q.size() == 0, 2'h0}, 8'h0c);
    finish_test;
  end
endmodule
